// >>> video_port_cfg.sv
// Configuration, frame timing and capture sizing for two video capture channels.
// Assumes sync and clock pins arrive asynchronously; a 10 MHz system clock samples them.
`timescale 1ns/10ps
`include "video_port_defs.svh"
module video_port_cfg #(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  // Register port
  input  wire logic [`VP_ADDR_W-1:0]   i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // Capture pins
  input  wire logic                    i_video_clock_pin_a,
  input  wire logic                    i_video_clock_pin_b,
  input  wire logic [NCH-1:0]          i_vsync,
  input  wire logic [NCH-1:0]          i_hvalid,
  input  wire logic [NCH-1:0]          i_vvalid,
  // Channel status and DMA requests
  output logic      [NCH-1:0]          o_active,
  output logic      [NCH-1:0]          o_line_end,
  output video_port_pkg::burst_t [NCH-1:0] o_burst,
  output logic      [NCH-1:0]          o_burst_req
);
  // Reset is taken at once but left through two flops, so no flop sees the release close to its edge.
  logic [1:0]     rst_sync_r;
  wire            rst_n = rst_sync_r[1];
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // Clock pins and per-channel strobes pass two flops before use.
  logic [1:0]     clka_s_r;
  logic [1:0]     clkb_s_r;
  logic [NCH-1:0] vs_s1_r;
  logic [NCH-1:0] vs_s2_r;
  logic [NCH-1:0] hv_s1_r;
  logic [NCH-1:0] hv_s2_r;
  logic [NCH-1:0] vv_s1_r;
  logic [NCH-1:0] vv_s2_r;
  logic           clk0_prev_r;
  logic           clk1_prev_r;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clka_s_r <= 2'h0;
      clkb_s_r <= 2'h0;
      vs_s1_r <= '0;
      vs_s2_r <= '0;
      hv_s1_r <= '0;
      hv_s2_r <= '0;
      vv_s1_r <= '0;
      vv_s2_r <= '0;
    end else begin
      clka_s_r <= {clka_s_r[0], i_video_clock_pin_a};
      clkb_s_r <= {clkb_s_r[0], i_video_clock_pin_b};
      vs_s1_r <= i_vsync;
      vs_s2_r <= vs_s1_r;
      hv_s1_r <= i_hvalid;
      hv_s2_r <= hv_s1_r;
      vv_s1_r <= i_vvalid;
      vv_s2_r <= vv_s1_r;
    end
  end

  // Global registers.
  logic [NCH-1:0] en_r;
  logic [NCH-1:0] raw_r;
  logic           chan1_clock_select_r;
  logic [`VP_DMA_W-1:0] dma_size_r;
  wire  dma_hit = (i_addr == `VP_OFS_DMA_SIZE);
  wire  clk_hit = (i_addr == `VP_OFS_CLK_SEL);
  wire  sts_hit = (i_addr == `VP_OFS_CH_STATUS);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_size_r <= `VP_DMA_RST;
    end else if (i_wr && dma_hit) begin
      dma_size_r <= i_wdata[`VP_DMA_W-1:0];
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan1_clock_select_r <= 1'b0;
    end else if (i_wr && clk_hit) begin
      chan1_clock_select_r <= i_wdata[`VP_BIT_CH1_CLK];
    end
  end

  // Channel one pixel clock follows the select bit; both channels share pin a when it is zero.
  wire clk1_now = chan1_clock_select_r ? clkb_s_r[1] : clka_s_r[1];
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk0_prev_r <= 1'b0;
      clk1_prev_r <= 1'b0;
    end else begin
      clk0_prev_r <= clka_s_r[1];
      clk1_prev_r <= clk1_now;
    end
  end
  // One pixel is taken per rising pixel clock edge; the pixel clock must stay below half the system clock.
  // Switching the select bit may add one stray pixel, so change it only while channel one is stopped.
  wire [NCH-1:0] pix_tick;
  assign pix_tick[0] = clka_s_r[1] & ~clk0_prev_r;
  assign pix_tick[1] = clk1_now & ~clk1_prev_r;

  logic [NCH-1:0][31:0] ch_rdata;
  logic [NCH-1:0][31:0] cfg_rdata;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      video_port_pkg::chan_cfg_t   shadow_r;
      video_port_pkg::chan_cfg_t   live_r;
      video_port_pkg::chan_state_t st_r;
      logic [`VP_BYTE_W-1:0]       byte_cnt_r;
      logic [`VP_BYTE_W-1:0]       width_r;
      logic [`VP_LINE_W-1:0]       line_cnt_r;
      logic [`VP_LINE_W-1:0]       height_r;
      logic [31:0]                 wr_addr_r;
      logic [31:0]                 burst_addr_r;
      logic [15:0]                 beat_acc_r;
      logic                        hv_prev_r;
      logic                        vs_prev_r;
      logic                        pend_r;

      wire  [7:0] ch_base = `VP_OFS_CH_BASE + 8'(g << `VP_CH_STRIDE_SH);
      wire  [7:0] ctl_ofs = `VP_OFS_CH0_CTRL + 8'(g << 2);
      wire  in_ch   = i_addr[7:6] == ch_base[7:6];
      wire  [5:0] lo = i_addr[5:0];
      wire  ctl_wr  = i_wr && (i_addr == ctl_ofs);
      wire  cfg_wr  = i_wr && in_ch;
      wire  vs_fall = vs_prev_r & ~vs_s2_r[g];
      wire  hv_rise = hv_s2_r[g] & ~hv_prev_r;
      wire  hv_fall = hv_prev_r & ~hv_s2_r[g];
      wire  beat    = pix_tick[g] & hv_s2_r[g] & vv_s2_r[g] & st_r == video_port_pkg::ST_RUN;
      wire  [7:0] beats = 8'(1 << live_r.dma_size);
      wire  [15:0] burst_bytes = 16'(beats) * `VP_BEAT_BYTES;
      // Active size is the unsigned active byte count alone; raw mode measures instead.
      wire  [`VP_BYTE_W-1:0] line_len = live_r.raw_mode ? width_r : live_r.active_bytes;
      wire  line_done = live_r.raw_mode ? hv_fall : (byte_cnt_r == line_len - 1'b1) && beat;
      // Programmed frames stop counting at the frame height; raw frames are bounded only by sync.
      wire  frame_full = !live_r.raw_mode && line_cnt_r == live_r.frame_lines;
      // Settings read back from the shadow copy, so software sees its writes before the next sync.
      wire  [31:0] cfg_rd =
        (lo == `VP_OFS_BUF_ADDR)  ? shadow_r.buf_addr :
        (lo == `VP_OFS_ADDR_OFST) ? shadow_r.addr_ofst :
        (lo == `VP_OFS_HSIZE)     ? {3'h0, shadow_r.blank_bytes, 3'h0, shadow_r.active_bytes} :
        (lo == `VP_OFS_VCFG_A)    ? {4'h0, shadow_r.mark_one, 4'h0, shadow_r.mark_three} :
        (lo == `VP_OFS_VCFG_B)    ? {4'h0, shadow_r.mark_five, 16'h0000} :
        (lo == `VP_OFS_VSIZE)     ? {20'h0_0000, shadow_r.frame_lines} : 32'h0000_0000;
      assign cfg_rdata[g] = in_ch ? cfg_rd : 32'h0000_0000;

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          shadow_r <= '0;
          en_r[g] <= 1'b0;
          raw_r[g] <= 1'b0;
        end else begin
          if (ctl_wr) begin
            en_r[g] <= i_wdata[`VP_BIT_EN];
            raw_r[g] <= i_wdata[`VP_BIT_RAW];
          end
          shadow_r.raw_mode <= raw_r[g];
          shadow_r.dma_size <= dma_size_r;
          if (cfg_wr && lo == `VP_OFS_HSIZE) begin
            shadow_r.blank_bytes  <= i_wdata[28:16];
            shadow_r.active_bytes <= i_wdata[12:0];
          end
          if (cfg_wr && lo == `VP_OFS_VCFG_A) begin
            shadow_r.mark_one   <= i_wdata[27:16];
            shadow_r.mark_three <= i_wdata[11:0];
          end
          if (cfg_wr && lo == `VP_OFS_VCFG_B) shadow_r.mark_five <= i_wdata[27:16];
          if (cfg_wr && lo == `VP_OFS_VSIZE) shadow_r.frame_lines <= i_wdata[11:0];
          if (cfg_wr && lo == `VP_OFS_BUF_ADDR) shadow_r.buf_addr <= i_wdata;
          if (cfg_wr && lo == `VP_OFS_ADDR_OFST) shadow_r.addr_ofst <= i_wdata;
        end
      end

      // Settings land only on a vsync falling edge, so a frame never sees a half-written set.
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          live_r <= '0;
          st_r <= video_port_pkg::ST_IDLE;
          vs_prev_r <= 1'b0;
          hv_prev_r <= 1'b0;
        end else begin
          vs_prev_r <= vs_s2_r[g];
          hv_prev_r <= hv_s2_r[g];
          if (!en_r[g]) begin
            st_r <= video_port_pkg::ST_IDLE;
          end else begin
            case (st_r)
              video_port_pkg::ST_IDLE: begin
                st_r <= video_port_pkg::ST_WAIT_VS;
              end
              video_port_pkg::ST_WAIT_VS: begin
                if (vs_fall) st_r <= video_port_pkg::ST_RUN;
              end
              default: begin
                st_r <= video_port_pkg::ST_RUN;
              end
            endcase
          end
          if (vs_fall) live_r <= shadow_r;
        end
      end

      // Counters measure width and height; raw frames keep the measured size.
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          byte_cnt_r <= '0;
          line_cnt_r <= '0;
          width_r <= '0;
          height_r <= '0;
          wr_addr_r <= '0;
          burst_addr_r <= '0;
          beat_acc_r <= '0;
          pend_r <= 1'b0;
        end else if (st_r != video_port_pkg::ST_RUN || vs_fall) begin
          byte_cnt_r <= '0;
          line_cnt_r <= '0;
          beat_acc_r <= '0;
          pend_r <= 1'b0;
          // The new frame starts from the settings that this same sync edge loads.
          wr_addr_r <= vs_fall ? shadow_r.buf_addr : live_r.buf_addr;
          if (vs_fall && line_cnt_r != '0) height_r <= line_cnt_r;
        end else begin
          pend_r <= 1'b0;
          if (beat) begin
            byte_cnt_r <= byte_cnt_r + 1'b1;
            beat_acc_r <= beat_acc_r + 1'b1;
            if (beat_acc_r + 1'b1 == burst_bytes) begin
              beat_acc_r <= '0;
              pend_r <= 1'b1;
              burst_addr_r <= wr_addr_r;
              wr_addr_r <= wr_addr_r + 32'(burst_bytes);
            end
          end
          if (hv_rise) byte_cnt_r <= '0;
          if (hv_fall && live_r.raw_mode) width_r <= byte_cnt_r;
          if (line_done && !frame_full) begin
            line_cnt_r <= line_cnt_r + 1'b1;
            wr_addr_r <= live_r.buf_addr + live_r.addr_ofst * 32'(line_cnt_r + 1'b1);
            beat_acc_r <= '0;
          end
        end
      end

      // Outputs come from flops so the far side never sees decode glitches.
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_active[g] <= 1'b0;
          o_line_end[g] <= 1'b0;
          o_burst[g] <= '0;
          o_burst_req[g] <= 1'b0;
        end else begin
          o_active[g] <= st_r == video_port_pkg::ST_RUN;
          o_line_end[g] <= line_done && st_r == video_port_pkg::ST_RUN;
          o_burst_req[g] <= pend_r;
          o_burst[g] <= '{addr: burst_addr_r, beats: beats};
        end
      end
      assign ch_rdata[g] = {4'h0, height_r, 3'h0, width_r};
    end
  endgenerate

  // Status shows each channel's running state; measured sizes read at the third and fourth control slots.
  wire ctl0_hit = (i_addr == `VP_OFS_CH0_CTRL);
  wire ctl1_hit = (i_addr == `VP_OFS_CH1_CTRL);
  wire siz0_hit = (i_addr == `VP_OFS_CH2_CTRL);
  wire siz1_hit = (i_addr == `VP_OFS_CH3_CTRL);
  wire [31:0] rd_mux = dma_hit  ? 32'({dma_size_r}) :
                       clk_hit  ? 32'({chan1_clock_select_r, 4'h0}) :
                       sts_hit  ? 32'({o_active, en_r}) :
                       ctl0_hit ? 32'({raw_r[0], en_r[0]}) :
                       ctl1_hit ? 32'({raw_r[1], en_r[1]}) :
                       siz0_hit ? ch_rdata[0] :
                       siz1_hit ? ch_rdata[1] : (cfg_rdata[0] | cfg_rdata[1]);
  // Read data stands for one cycle only and is zero otherwise, so stale data never looks fresh.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule

// >>> video_port_defs.svh
// Register offsets, field positions and reset values of the video port configuration block.
// Assumes a 32-bit plain register port with byte addresses in words of four.
`ifndef VIDEO_PORT_DEFS_SVH
`define VIDEO_PORT_DEFS_SVH
`define VP_ADDR_W          8
`define VP_OFS_CH0_CTRL    8'h04
`define VP_OFS_CH1_CTRL    8'h08
`define VP_OFS_CH2_CTRL    8'h0C
`define VP_OFS_CH3_CTRL    8'h10
`define VP_OFS_DMA_SIZE    8'h38
`define VP_OFS_CLK_SEL     8'hF0
`define VP_OFS_CH_STATUS   8'hF4
`define VP_OFS_CH_BASE     8'h40
`define VP_CH_STRIDE_SH    6
`define VP_OFS_BUF_ADDR    6'h00
`define VP_OFS_ADDR_OFST   6'h24
`define VP_OFS_HSIZE       6'h2C
`define VP_OFS_VCFG_A      6'h30
`define VP_OFS_VCFG_B      6'h34
`define VP_OFS_VSIZE       6'h3C
`define VP_BIT_EN          0
`define VP_BIT_RAW         1
`define VP_BIT_CH1_CLK     4
`define VP_DMA_W           3
`define VP_DMA_RST         3'h0
`define VP_BEAT_BYTES      16'h0008
`define VP_LINE_W          12
`define VP_BYTE_W          13
`endif

// >>> video_port_pkg.sv
// Types shared by the video port configuration block.
// Assumes the constants of video_port_defs.svh.
package video_port_pkg;
  typedef struct packed {
    logic [12:0] blank_bytes;
    logic [12:0] active_bytes;
    logic [11:0] frame_lines;
    logic [11:0] mark_one;
    logic [11:0] mark_three;
    logic [11:0] mark_five;
    logic [31:0] buf_addr;
    logic [31:0] addr_ofst;
    logic        raw_mode;
    logic [2:0]  dma_size;
  } chan_cfg_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  beats;
  } burst_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_VS, ST_RUN} chan_state_t;
endpackage

// >>> video_port_cfg_assertions.sv
// Concurrent checks on the ports of the video port configuration block.
// Assumes one system clock domain and the offsets of the shared header.
`timescale 1ns/10ps
`include "video_port_defs.svh"
module video_port_cfg_checker #(
  parameter int NCH = 2
) (
  input wire logic                          i_clk,
  input wire logic                          i_arst_n,
  input wire logic [`VP_ADDR_W-1:0]         i_addr,
  input wire logic [31:0]                   i_wdata,
  input wire logic                          i_wr,
  input wire logic                          i_rd,
  input wire logic [31:0]                   o_rdata,
  input wire logic                          i_video_clock_pin_a,
  input wire logic                          i_video_clock_pin_b,
  input wire logic [NCH-1:0]                i_vsync,
  input wire logic [NCH-1:0]                i_hvalid,
  input wire logic [NCH-1:0]                i_vvalid,
  input wire logic [NCH-1:0]                o_active,
  input wire logic [NCH-1:0]                o_line_end,
  input wire video_port_pkg::burst_t [NCH-1:0] o_burst,
  input wire logic [NCH-1:0]                o_burst_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_clk_sel_bits: assert property ($past(i_rd && i_addr == `VP_OFS_CLK_SEL) |-> (o_rdata & ~32'h10) == 32'h0)
    else $error("clock select reads reserved bits");
  a_stop_ch0_now: assert property (i_wr && i_addr == `VP_OFS_CH0_CTRL && !i_wdata[0] |-> ##[1:3] !o_active[0])
    else $error("channel 0 did not stop");
  a_stop_ch1_now: assert property (i_wr && i_addr == `VP_OFS_CH1_CTRL && !i_wdata[0] |-> ##[1:3] !o_active[1])
    else $error("channel 1 did not stop");
  a_start_waits_vs: assert property (i_wr && i_addr == `VP_OFS_CH0_CTRL && !o_active[0] |=> !o_active[0] [*2])
    else $error("channel started without sync");
  a_beats_pow_two: assert property (o_burst_req[0] |-> $onehot(o_burst[0].beats))
    else $error("burst length not a power of two");
  a_burst_when_on: assert property (o_burst_req[0] |-> o_active[0] || $past(o_active[0]))
    else $error("burst from stopped channel");
  a_line_end_pulse: assert property (o_line_end[0] |=> !o_line_end[0])
    else $error("line end longer than one cycle");
  a_line_when_on: assert property (o_line_end[0] |-> o_active[0] || $past(o_active[0]))
    else $error("line end from stopped channel");
  a_status_active: assert property ($past(i_rd && i_addr == `VP_OFS_CH_STATUS) |-> o_rdata[3:2] == $past(o_active))
    else $error("status does not show running channels");
  c_started: cover property ($rose(o_active[0]));
  c_burst: cover property (o_burst_req[0]);
  c_line: cover property (o_line_end[0]);
endmodule
bind video_port_cfg video_port_cfg_checker #(.NCH(NCH)) u_chk (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_video_clock_pin_a, .i_video_clock_pin_b, .i_vsync, .i_hvalid, .i_vvalid, .o_active, .o_line_end,
  .o_burst, .o_burst_req);

// >>> video_source_model.sv
// Behavioural video source driving pixel clock, frame sync and valid lines.
// Assumes the consumer samples them asynchronously; the clock stands still while idle.
`timescale 1ns/10ps
module video_source_model #(
  parameter int W = 4,
  parameter int H = 3
) (
  // Control
  input  wire logic i_run,
  // Pins
  output logic      o_pclk,
  output logic      o_vsync,
  output logic      o_hvalid,
  output logic      o_vvalid
);
  task automatic tick(input int n);
    repeat (n) begin
      #400 o_pclk = 1'b1;
      #400 o_pclk = 1'b0;
    end
  endtask
  initial begin
    {o_pclk, o_vsync, o_hvalid, o_vvalid} = 4'h4;
    #37;
    forever begin
      if (!i_run)
        #100;
      else begin
        o_vsync = 1'b0;
        tick(2);
        o_vsync = 1'b1;
        tick(2);
        o_vvalid = 1'b1;
        repeat (H) begin
          o_hvalid = 1'b1;
          tick(W);
          o_hvalid = 1'b0;
          tick(3);
        end
        o_vvalid = 1'b0;
        tick(2);
      end
    end
  end
endmodule

// >>> tb_video_port_cfg.sv
// Self-checking bench for the video port configuration block.
// Assumes the behavioural video source feeds both capture channels.
`timescale 1ns/10ps
`include "video_port_defs.svh"
module tb_video_port_cfg;
  localparam int W = 8;
  localparam int H = 3;
  logic                        i_clk, i_arst_n, i_wr, i_rd, run, rd_d, pclk, vs, hv, vv;
  logic [`VP_ADDR_W-1:0]       i_addr;
  logic [31:0]                 i_wdata, o_rdata, r;
  logic [1:0]                  o_active, o_line_end, o_burst_req;
  video_port_pkg::burst_t [1:0] o_burst;
  logic [31:0]                 exp_q[$];
  logic [15:0]                 lfsr;
  int                          err_count, total_checks;
  int                          bline = 0;
  int                          nb = 0;
  int bl[2] = '{272, 362};
  int al[2] = '{1920, 1280};
  int fl[2] = '{1125, 750};
  int m3[2] = '{42, 26};
  int m5[2] = '{1122, 746};
  video_source_model #(.W(W), .H(H)) src (.i_run(run), .o_pclk(pclk), .o_vsync(vs), .o_hvalid(hv), .o_vvalid(vv));
  video_port_cfg #(.NCH(2)) DUT (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_video_clock_pin_a(pclk), .i_video_clock_pin_b(pclk), .i_vsync({vs, vs}), .i_hvalid({hv, hv}),
    .i_vvalid({vv, vv}), .o_active, .o_line_end, .o_burst, .o_burst_req);
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data is judged by the monitor below one cycle later.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  always @(posedge i_clk) begin
    if (rd_d)
      check("rdata", o_rdata, exp_q.pop_front());
    rd_d <= i_rd;
  end
  // Each raw line of eight pixels yields one single-beat burst at that line's start address.
  always @(posedge i_clk) begin
    if (o_burst_req[0] === 1'b1) begin
      check("burst_addr", o_burst[0].addr, r + 32'h0000_0800 * 32'(bline));
      check("burst_beats", {24'h0, o_burst[0].beats}, 32'h1);
      bline <= (bline == H - 1) ? 0 : bline + 1;
      nb <= nb + 1;
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    {i_arst_n, i_wr, i_rd, run} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    lfsr = 16'hCD71;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    wr(`VP_OFS_CLK_SEL, 32'hFFFFFFFF);
    rd(`VP_OFS_CLK_SEL, 32'h10);
    wr(`VP_OFS_CLK_SEL, 32'h0);
    rd(`VP_OFS_CLK_SEL, 32'h0);
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(`VP_OFS_DMA_SIZE, i);
      rd(`VP_OFS_DMA_SIZE, i);
    end
    lfsr = nxt(lfsr);
    r = {lfsr, ~lfsr};
    wr(8'h40, r);
    rd(8'h40, r);
    wr(8'h64, 32'h0000_0800);
    rd(8'h64, 32'h0000_0800);
    // Both timing tables are loaded and read back, mark five excepted; the top counts need 11 bits, so signed reads would fail.
    for (int f = 0; f < 2; f++) begin
      wr(8'h6C, {3'h0, 13'(bl[f]), 3'h0, 13'(al[f])});
      rd(8'h6C, {3'h0, 13'(bl[f]), 3'h0, 13'(al[f])});
      wr(8'h70, {4'h0, 12'h001, 4'h0, 12'(m3[f])});
      rd(8'h70, {4'h0, 12'h001, 4'h0, 12'(m3[f])});
      wr(8'h74, {4'h0, 12'(m5[f]), 16'h0});
      wr(8'h7C, {20'h0, 12'(fl[f])});
      rd(8'h7C, {20'h0, 12'(fl[f])});
    end
    lfsr = nxt(lfsr);
    wr(8'h6C, {3'h0, lfsr[12:0], 16'h0});
    wr(`VP_OFS_DMA_SIZE, 32'h0);
    wr(`VP_OFS_CH0_CTRL, 32'h3);
    repeat (50) @(posedge i_clk);
    check("active", {30'h0, o_active}, 32'h0);
    rd(`VP_OFS_CH_STATUS, 32'h1);
    run <= 1'b1;
    for (int n = 0; o_active[0] !== 1'b1; n++) begin
      if (n == 20000) begin
        err_count++;
        conclude();
      end
      @(posedge i_clk);
    end
    rd(`VP_OFS_CH_STATUS, 32'h5);
    repeat (700) @(posedge i_clk);
    rd(`VP_OFS_CH2_CTRL, {4'h0, 12'(H), 3'h0, 13'(W)});
    wr(`VP_OFS_CH0_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    check("stopped", {30'h0, o_active}, 32'h0);
    check("bursts", {31'h0, nb > 0}, 32'h1);
    wr(`VP_OFS_CH1_CTRL, 32'h0);
    run <= 1'b0;
    repeat (2) @(posedge i_clk);
    conclude();
  end
endmodule
